/* aac_handler.v */
// arm and calibrate command handler, top level
//
// Behaviour
// - external source: start arms shared input; group arms on selected slope edge
// - internal source: group arms at once on start command
// - zero setting 1 clears group memory before arming; 0 leaves it
// - missing group list means group 1; missing boolean means 0
// - sequence and qualifier_a fields accepted, ignored
// - armed indicator follows internal armed state only
// - one external arm input and one slope shared by all groups
// - new slope applies to groups already pending on external arm
// - gain-and-offset calibration for value 0.0796 to 19.90 volts
// - offset-only calibration rounds range 0.2..20.0 up to a real range
// - range zero calibrates offset of every range on channel
// - error indicator blinks while calibration runs; default 1000 us run ends before the first 250 ms toggle, so it stays dark
// - calibration first resets module, abandoning arming and sampling
// - after calibration all settings default; calibration errors stay queued
// - gain query gives offset then gain; offset query gives offset
// - completion shown by query result, complete bit and service request
// - failure details readable through error query
// - during calibration only common commands honoured, others ignored
// - missing channel means channel 1
// - external source enables shared input for group; internal is default
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "aac_regs.vh"
module aac_handler #(
   parameter NGRP = 4,
   parameter CAL_CYC = `AAC_CAL_CYC,
   parameter BLINK_CYC = `AAC_BLINK_CYC
) (
   input wire mclk,
   input wire reset_n,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rdata,
   input wire ext_arm_pin,
   input wire cal_fail_in,
   input wire [15:0] cal_meas_offset,
   input wire [15:0] cal_meas_gain,
   output reg [NGRP-1:0] grp_armed,
   output reg [NGRP-1:0] grp_mem_clear,
   output reg [NGRP-1:0] grp_abort,
   output wire armed_led,
   output reg err_led,
   output reg cal_active,
   output reg [3:0] cal_channel,
   output reg [2:0] cal_range,
   output reg cal_all_ranges,
   output reg cal_gain_en,
   output reg opc_bit,
   output reg srq
);
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_DONE = 2'd2;

   reg [31:0] cmd_arg_r;
   reg [NGRP-1:0] src_ext_r;
   reg [NGRP-1:0] zero_r;
   reg slope_neg_r;
   reg [NGRP-1:0] pend_r;
   reg [NGRP-1:0] zero_pend_r;
   reg [1:0] st_r;
   reg [31:0] cnt_r;
   reg [31:0] blink_r;
   reg [15:0] off_r;
   reg [15:0] gain_r;
   reg [15:0] err_code_r;
   reg [7:0] err_cnt_r;
   reg fail_r;
   reg ext_prev_r;
   wire ext_s;

   // -------------------------------------------------
   // command word decode
   // -------------------------------------------------
   wire [7:0] op = wdata[`AAC_CMD_OP_MSB:0];
   wire cmd_wr = wr_stb && (addr == `AAC_REG_CMD);
   // missing group list selects group 1 only
   wire [NGRP-1:0] grp_sel = wdata[`AAC_CMD_HAS_GRP] ? wdata[`AAC_CMD_GRP_LSB +: NGRP] :
                             {{(NGRP-1){1'b0}}, 1'b1};
   // missing boolean counts as 0
   wire bval = wdata[`AAC_CMD_HAS_VAL] & wdata[`AAC_CMD_VAL_BIT];
   // missing channel selects channel 1
   wire [3:0] ch_sel = wdata[`AAC_CMD_HAS_CH] ? wdata[`AAC_CMD_CH_MSB:`AAC_CMD_CH_LSB] : 4'h1;
   // the qualifier field (bits 31:20) is never read
   wire busy = (st_r != ST_IDLE);
   // while calibrating only common commands pass
   wire cmd_ok = cmd_wr && (!busy || op == `AAC_OP_COMMON);

   // calibration range rounding, millivolts to range code
   function [2:0] range_code;
      input [31:0] mv;
      begin
         if (mv <= 32'd200) range_code = 3'd0;
         else if (mv <= 32'd500) range_code = 3'd1;
         else if (mv <= 32'd1000) range_code = 3'd2;
         else if (mv <= 32'd2000) range_code = 3'd3;
         else if (mv <= 32'd5000) range_code = 3'd4;
         else if (mv <= 32'd10000) range_code = 3'd5;
         else range_code = 3'd6;
      end
   endfunction

   // value-to-range mapping for gain calibration by span
   function [2:0] span_code;
      input [31:0] mv;
      begin
         if (mv < 32'd199) span_code = 3'd0;
         else if (mv < 32'd499) span_code = 3'd1;
         else if (mv < 32'd999) span_code = 3'd2;
         else if (mv < 32'd1990) span_code = 3'd3;
         else if (mv < 32'd4990) span_code = 3'd4;
         else if (mv < 32'd9990) span_code = 3'd5;
         else span_code = 3'd6;
      end
   endfunction

   wire val_ok = (cmd_arg_r >= `AAC_CAL_VAL_MIN_MV) && (cmd_arg_r <= `AAC_CAL_VAL_MAX_MV);
   wire rng_ok = (cmd_arg_r == 32'd0) ||
                 ((cmd_arg_r >= 32'd200) && (cmd_arg_r <= `AAC_RANGE_MAX_MV));
   wire cal_go = cmd_ok && !busy && (op == `AAC_OP_CAL_VALUE || op == `AAC_OP_CAL_ZERO);
   wire cal_bad = cal_go && ((op == `AAC_OP_CAL_VALUE) ? !val_ok : !rng_ok);

   // -------------------------------------------------
   // shared external arm input
   // -------------------------------------------------
   aac_sync3 u_ext_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .din(ext_arm_pin),
      .dout(ext_s)
   );
   // single input, single slope for every group
   wire ext_edge = slope_neg_r ? (ext_prev_r & ~ext_s) : (~ext_prev_r & ext_s);
   // arming already due this cycle; a command landing in the same cycle must not drop it
   wire [NGRP-1:0] arm_due = zero_pend_r | (ext_edge ? pend_r : {NGRP{1'b0}});
   wire [NGRP-1:0] pend_left = ext_edge ? {NGRP{1'b0}} : pend_r;

   assign armed_led = |grp_armed; // internal armed state only

   // -------------------------------------------------
   // arming, settings, calibration sequencing
   // -------------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_arg_r <= 32'h0;
         src_ext_r <= {NGRP{1'b0}};
         zero_r <= {NGRP{1'b0}};
         slope_neg_r <= 1'b0;
         pend_r <= {NGRP{1'b0}};
         zero_pend_r <= {NGRP{1'b0}};
         grp_armed <= {NGRP{1'b0}};
         grp_mem_clear <= {NGRP{1'b0}};
         grp_abort <= {NGRP{1'b0}};
         st_r <= ST_IDLE;
         cnt_r <= 32'h0;
         cal_active <= 1'b0;
         cal_channel <= 4'h1;
         cal_range <= 3'd0;
         cal_all_ranges <= 1'b0;
         cal_gain_en <= 1'b0;
         off_r <= 16'h0;
         gain_r <= 16'h0;
         fail_r <= 1'b0;
         opc_bit <= 1'b0;
         srq <= 1'b0;
         err_code_r <= 16'h0;
         err_cnt_r <= 8'h0;
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_s;
         grp_mem_clear <= {NGRP{1'b0}};
         grp_abort <= {NGRP{1'b0}};
         // memory clear pulse lands the cycle before internal arming
         grp_armed <= grp_armed | zero_pend_r;
         zero_pend_r <= {NGRP{1'b0}};
         if (ext_edge) begin
            grp_armed <= grp_armed | zero_pend_r | pend_r;
            pend_r <= {NGRP{1'b0}};
         end
         if (wr_stb && addr == `AAC_REG_CMD_ARG && !busy) cmd_arg_r <= wdata;
         // error reading pops one entry; a new error in the same cycle wins
         if (rd_stb && addr == `AAC_REG_ERR && err_cnt_r != 8'h0) err_cnt_r <= err_cnt_r - 8'h01;
         if (cmd_ok && !busy) begin
            case (op)
               `AAC_OP_ARM_SOURCE: src_ext_r <= (src_ext_r & ~grp_sel) | (bval ? grp_sel : {NGRP{1'b0}});
               `AAC_OP_ARM_ZERO: zero_r <= (zero_r & ~grp_sel) | (bval ? grp_sel : {NGRP{1'b0}});
               `AAC_OP_ARM_SLOPE: slope_neg_r <= bval;
               `AAC_OP_START_ACQ: begin
                  grp_mem_clear <= grp_sel & zero_r;
                  zero_pend_r <= grp_sel & ~src_ext_r & zero_r;
                  grp_armed <= grp_armed | arm_due | (grp_sel & ~src_ext_r & ~zero_r);
                  pend_r <= pend_left | (grp_sel & src_ext_r);
                  if (wdata[`AAC_CMD_HAS_VAL]) slope_neg_r <= wdata[`AAC_CMD_VAL_BIT];
               end
               `AAC_OP_ABORT: begin
                  grp_armed <= (grp_armed | arm_due) & ~grp_sel;
                  pend_r <= pend_left & ~grp_sel;
                  grp_abort <= grp_sel;
               end
               default: ;
            endcase
         end
         // -------- calibration --------
         case (st_r)
            ST_IDLE: begin
               if (cal_bad) begin
                  err_code_r <= `AAC_ERR_RANGE; // constants untouched
                  if (err_cnt_r != 8'hff) err_cnt_r <= err_cnt_r + 8'h01;
               end else if (cal_go) begin
                  // module reset first
                  grp_abort <= {NGRP{1'b1}};
                  grp_armed <= {NGRP{1'b0}};
                  pend_r <= {NGRP{1'b0}};
                  zero_pend_r <= {NGRP{1'b0}};
                  grp_mem_clear <= {NGRP{1'b0}};
                  cal_channel <= ch_sel;
                  cal_gain_en <= (op == `AAC_OP_CAL_VALUE);
                  cal_all_ranges <= (op == `AAC_OP_CAL_ZERO) && (cmd_arg_r == 32'd0);
                  cal_range <= (op == `AAC_OP_CAL_VALUE) ? span_code(cmd_arg_r) : range_code(cmd_arg_r);
                  cal_active <= 1'b1;
                  opc_bit <= 1'b0;
                  srq <= 1'b0;
                  fail_r <= 1'b0;
                  cnt_r <= 32'h0;
                  st_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (cal_fail_in) fail_r <= 1'b1;
               if (cnt_r >= CAL_CYC - 1) st_r <= ST_DONE;
               else cnt_r <= cnt_r + 32'h1;
            end
            ST_DONE: begin
               // restore defaults; error queue kept
               src_ext_r <= {NGRP{1'b0}};
               zero_r <= {NGRP{1'b0}};
               slope_neg_r <= 1'b0;
               cal_active <= 1'b0;
               off_r <= cal_meas_offset;
               gain_r <= cal_gain_en ? cal_meas_gain : gain_r;
               opc_bit <= 1'b1;
               srq <= 1'b1;
               if (fail_r || cal_fail_in) begin
                  err_code_r <= `AAC_ERR_CAL;
                  if (err_cnt_r != 8'hff) err_cnt_r <= err_cnt_r + 8'h01;
               end
               st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
         // reading status acknowledges service request; completion wins over it
         if (rd_stb && addr == `AAC_REG_STATUS && st_r != ST_DONE) srq <= 1'b0;
      end
   end

   // -------------------------------------------------
   // error indicator blink while calibrating
   // -------------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         blink_r <= 32'h0;
         err_led <= 1'b0;
      end else if (!cal_active) begin
         blink_r <= 32'h0;
         err_led <= 1'b0; // stops as soon as calibration ends
      end else if (blink_r >= BLINK_CYC - 1) begin
         blink_r <= 32'h0;
         err_led <= ~err_led;
      end else begin
         blink_r <= blink_r + 32'h1;
      end
   end

   // -------------------------------------------------
   // register read port, data one cycle after strobe
   // -------------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h0;
      end else if (rd_stb) begin
         case (addr)
            `AAC_REG_CMD_ARG: rdata <= cmd_arg_r;
            `AAC_REG_STATUS: rdata <= {29'h0, fail_r, opc_bit, cal_active};
            `AAC_REG_ARM_SRC: rdata <= {{(32-NGRP){1'b0}}, src_ext_r};
            `AAC_REG_ARM_ZERO: rdata <= {{(32-NGRP){1'b0}}, zero_r};
            `AAC_REG_ARM_SLOPE: rdata <= {31'h0, slope_neg_r};
            `AAC_REG_CAL_OFFSET: rdata <= {16'h0, off_r};
            `AAC_REG_CAL_GAIN: rdata <= {off_r, gain_r}; // offset then gain
            `AAC_REG_ERR: rdata <= (err_cnt_r != 8'h0) ? {16'h0, err_code_r} : 32'h0;
            `AAC_REG_ERR_COUNT: rdata <= {24'h0, err_cnt_r};
            `AAC_REG_ID: rdata <= `AAC_ID_VALUE; // arbitrary value
            default: rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end
endmodule // aac_handler
`default_nettype wire

/* aac_handler_bench.sv */
// self-checking bench for the arm and calibrate command handler
`timescale 1ns/100ps
`default_nettype none
`include "aac_regs.vh"
module aac_handler_bench;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ext_arm_pin = 1'b0;
   logic cal_fail_in = 1'b0;
   logic [15:0] m_off = 16'h0;
   logic [15:0] m_gain = 16'h0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, v, a;
   logic wr_stb, rd_stb, ok, led, err_led, cal_active, all_r, gain_en, opc_bit, srq;
   logic [3:0] armed, mclr, abrt, ch, c, zm;
   logic [2:0] rng;
   logic [3:0] clr_seen = 4'h0;
   logic [3:0] arm_cal = 4'h0;
   logic in_cal = 1'b0;
   logic blink = 1'b0;
   logic cal_prev = 1'b0;
   logic [8:0] snap = 9'h0;
   int bad_count = 0;
   int checks = 0;
   integer seed = 79875;
   int i;
   always #12.5 mclk = ~mclk;
   aac_handler #(.NGRP(4), .CAL_CYC(20), .BLINK_CYC(4)) dut_u (
      .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .ext_arm_pin(ext_arm_pin), .cal_fail_in(cal_fail_in), .cal_meas_offset(m_off),
      .cal_meas_gain(m_gain), .grp_armed(armed), .grp_mem_clear(mclr), .grp_abort(abrt), .armed_led(led),
      .err_led(err_led), .cal_active(cal_active), .cal_channel(ch), .cal_range(rng), .cal_all_ranges(all_r),
      .cal_gain_en(gain_en), .opc_bit(opc_bit), .srq(srq));
   aac_host host_u (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
   // gather what the handler did between checks
   always @(posedge mclk) begin
      clr_seen <= clr_seen | mclr;
      cal_prev <= cal_active;
      if (cal_active) begin
         in_cal <= 1'b1;
         blink <= blink | err_led;
         snap <= {rng, gain_en, all_r, ch};
      end
      if (cal_active && cal_prev)
         arm_cal <= arm_cal | armed;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic finish_test;
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // command word; the qualifier field is random since the handler must ignore it
   function automatic logic [31:0] cw(input logic [7:0] op, input logic [3:0] g, input logic [3:0] f,
                                      input logic [3:0] cn);
      cw = {12'($random(seed)), cn, f, g, op};
   endfunction
   // offset range index a requested span rounds up to
   function automatic logic [2:0] exp_rng(input logic [31:0] mv);
      exp_rng = mv <= 200 ? 3'h0 : mv <= 500 ? 3'h1 : mv <= 1000 ? 3'h2 : mv <= 2000 ? 3'h3 :
                mv <= 5000 ? 3'h4 : mv <= 10000 ? 3'h5 : 3'h6;
   endfunction
   // flags are cleared off the clock edge so the monitor never races them
   task automatic clr;
      @(negedge mclk);
      clr_seen = 4'h0;
      arm_cal = 4'h0;
      in_cal = 1'b0;
      blink = 1'b0;
   endtask
   task automatic wait_arm(input logic [3:0] e);
      for (int n = 0; n < 20 && armed !== e; n++)
         @(negedge mclk);
      chk("grp_armed", 32'(e), 32'(armed));
   endtask
   task automatic pin(input logic l);
      @(posedge mclk);
      ext_arm_pin <= l;
      repeat (12) @(negedge mclk);
   endtask
   // a start attempt rides along while the calibration is busy
   task automatic run_cal(input logic [7:0] op, input logic [31:0] av, input logic [3:0] f, input logic [3:0] cn);
      clr;
      m_off = 16'($random(seed));
      m_gain = 16'($random(seed));
      host_u.wr(`AAC_REG_CMD_ARG, av);
      host_u.wr(`AAC_REG_CMD, cw(op, 4'h0, f, cn));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_START_ACQ, 4'hf, 4'h2, 4'h0));
      host_u.wait_done(ok, v);
   endtask
   // a hang is cut short here
   initial begin
      repeat (100000) @(posedge mclk);
      bad_count++;
      finish_test;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      host_u.rd(`AAC_REG_ARM_SRC, v);
      chk("arm_src", 32'h0, v);
      host_u.rd(8'hfc, v);
      chk("unmapped", 32'h0, v);
      clr;
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_START_ACQ, 4'h0, 4'h0, 4'h0));
      wait_arm(4'h1);
      chk("mem_clear", 32'h0, 32'(clr_seen));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_ABORT, 4'hf, 4'h2, 4'h0));
      wait_arm(4'h0);
      zm = 4'($random(seed));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_ARM_ZERO, zm, 4'h7, 4'h0));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_ARM_ZERO, 4'h0, 4'h0, 4'h0));
      host_u.rd(`AAC_REG_ARM_ZERO, v);
      chk("arm_zero", 32'(zm & 4'he), v);
      clr;
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_START_ACQ, 4'hf, 4'h2, 4'h0));
      wait_arm(4'hf);
      chk("mem_clear", 32'(zm & 4'he), 32'(clr_seen));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_ABORT, 4'hf, 4'h2, 4'h0));
      wait_arm(4'h0);
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_ARM_SOURCE, 4'ha, 4'h7, 4'h0));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_ARM_SLOPE, 4'h0, 4'h5, 4'h0));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_START_ACQ, 4'h2, 4'h2, 4'h0));
      pin(1'b1);
      chk("grp_armed", 32'h0, 32'(armed));
      host_u.wr(`AAC_REG_CMD, cw(`AAC_OP_START_ACQ, 4'h8, 4'h6, 4'h0));
      pin(1'b0);
      chk("grp_armed", 32'h0, 32'(armed));
      pin(1'b1);
      wait_arm(4'ha);
      chk("armed_led", 32'h1, 32'(led));
      a = 32'd80 + {$random(seed)} % 32'd19821;
      run_cal(`AAC_OP_CAL_VALUE, a, 4'h0, 4'h0);
      chk("done", 32'h1, 32'(ok));
      chk("armed_in_cal", 32'h0, 32'(arm_cal));
      chk("blink", 32'h1, 32'(blink));
      chk("cal_ctl", 32'h21, 32'(snap[5:0]));
      host_u.rd(`AAC_REG_ARM_SRC, v);
      chk("arm_src", 32'h0, v);
      host_u.rd(`AAC_REG_CAL_GAIN, v);
      chk("cal_gain", {m_off, m_gain}, v);
      host_u.rd(`AAC_REG_CAL_OFFSET, v);
      chk("cal_offset", {16'h0, m_off}, v);
      run_cal(`AAC_OP_CAL_ZERO, 32'h0, 4'h8, 4'h5);
      chk("cal_ctl", 32'h15, 32'(snap[5:0]));
      for (i = 0; i < 4; i++) begin
         a = i == 0 ? 32'd200 : i == 1 ? 32'd20000 : 32'd200 + {$random(seed)} % 32'd19801;
         c = 4'h1 + 4'({$random(seed)} % 15);
         run_cal(`AAC_OP_CAL_ZERO, a, 4'h8, c);
         chk("cal_ctl", 32'({exp_rng(a), 2'b00, c}), 32'(snap));
      end
      cal_fail_in <= 1'b1;
      run_cal(`AAC_OP_CAL_VALUE, 32'd19900, 4'h0, 4'h0);
      cal_fail_in <= 1'b0;
      chk("err_code", 32'(`AAC_ERR_CAL), v);
      for (i = 0; i < 3; i++) begin
         clr;
         host_u.wr(`AAC_REG_CMD_ARG, i == 0 ? 32'd79 : i == 1 ? 32'd19901 : 32'd199);
         host_u.wr(`AAC_REG_CMD, cw(i == 2 ? `AAC_OP_CAL_ZERO : `AAC_OP_CAL_VALUE, 4'h0, 4'h0, 4'h0));
         host_u.rd(`AAC_REG_ERR_COUNT, v);
         chk("err_count", 32'h1, v);
         host_u.rd(`AAC_REG_ERR, v);
         chk("err_code", 32'(`AAC_ERR_RANGE), v);
         chk("cal_run", 32'h0, 32'(in_cal));
      end
      finish_test;
   end
endmodule // aac_handler_bench
`default_nettype wire

/* aac_handler_props.sv */
// assertions on the ports of the arm and calibrate command handler
`timescale 1ns/100ps
`default_nettype none
module aac_handler_props #(
   parameter NGRP = 4,
   parameter CAL_CYC = 20,
   parameter BLINK_CYC = 4
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [NGRP-1:0] grp_armed,
   input wire logic [NGRP-1:0] grp_mem_clear,
   input wire logic [NGRP-1:0] grp_abort,
   input wire logic armed_led,
   input wire logic err_led,
   input wire logic cal_active,
   input wire logic [3:0] cal_channel,
   input wire logic [2:0] cal_range,
   input wire logic opc_bit,
   input wire logic srq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   logic [31:0] run_c;
   logic [31:0] hold_c;
   logic led_q;
   // counters instead of long repetitions keep the checks cheap to unroll
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         run_c <= 32'h0;
         hold_c <= 32'h0;
         led_q <= 1'b0;
      end else begin
         run_c <= cal_active ? run_c + 32'h1 : 32'h0;
         hold_c <= (!cal_active || err_led != led_q) ? 32'h0 : hold_c + 32'h1;
         led_q <= err_led;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   sequence s_clear;
      grp_mem_clear != '0;
   endsequence
   sequence s_done;
      (opc_bit && grp_armed == '0) ##1 opc_bit;
   endsequence
   a_led_follow: assert property (armed_led == |grp_armed)
      else $error("armed led differs from armed groups");
   a_err_quiet: assert property (!cal_active && !$past(cal_active) |-> !err_led)
      else $error("error led lit outside calibration");
   a_blink_runs: assert property (cal_active |-> hold_c <= BLINK_CYC + 1)
      else $error("error led stopped blinking in calibration");
   a_abort_first: assert property ($rose(cal_active) |-> grp_abort == {NGRP{1'b1}})
      else $error("calibration began without aborting all groups");
   a_idle_in_cal: assert property (cal_active && $past(cal_active) |-> grp_armed == '0 && grp_mem_clear == '0)
      else $error("group activity during calibration");
   a_cal_length: assert property ($fell(cal_active) |-> run_c == CAL_CYC + 1)
      else $error("calibration run length wrong");
   a_done_flags: assert property ($fell(cal_active) |-> s_done)
      else $error("completion flags or defaults wrong at calibration end");
   a_opc_source: assert property ($rose(opc_bit) |-> $fell(cal_active))
      else $error("complete bit rose without calibration end");
   a_srq_done: assert property ($rose(srq) |-> opc_bit && !cal_active)
      else $error("service request without completion");
   a_settings_hold: assert property (cal_active && $past(cal_active) |-> $stable(cal_channel) && $stable(cal_range))
      else $error("calibration target moved during run");
   // externally armed groups clear at start and arm much later, so only the order is checked here
   a_clear_first: assert property (s_clear |-> (grp_mem_clear & grp_armed & ~$past(grp_armed)) == '0)
      else $error("group armed in the same cycle as its memory clear");
endmodule // aac_handler_props
bind aac_handler aac_handler_props #(.NGRP(NGRP), .CAL_CYC(CAL_CYC), .BLINK_CYC(BLINK_CYC)) chk_u (
   .mclk(mclk), .reset_n(reset_n), .grp_armed(grp_armed), .grp_mem_clear(grp_mem_clear),
   .grp_abort(grp_abort), .armed_led(armed_led), .err_led(err_led), .cal_active(cal_active),
   .cal_channel(cal_channel), .cal_range(cal_range), .opc_bit(opc_bit), .srq(srq));
`default_nettype wire

/* aac_host.sv */
// host controller model: register bus master for the command handler
`timescale 1ns/100ps
`default_nettype none
`include "aac_regs.vh"
module aac_host (
   input wire logic mclk,
   input wire logic [31:0] rdata,
   output var logic [7:0] addr,
   output var logic [31:0] wdata,
   output var logic wr_stb,
   output var logic rd_stb
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // one-cycle write; address and data are scrambled once the hold is over
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   // one-cycle read; data stands only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask
   // polls the complete bit, then fetches the error after a failure
   task automatic wait_done(output logic ok, output logic [31:0] err);
      logic [31:0] st;
      ok = 1'b0;
      err = 32'h0;
      st = 32'h0;
      for (int n = 0; n < 100 && !ok; n++) begin
         rd(`AAC_REG_STATUS, st);
         ok = (st[`AAC_ST_OPC] === 1'b1) && (st[`AAC_ST_CAL_BUSY] === 1'b0);
      end
      if (st[`AAC_ST_CAL_FAIL] === 1'b1)
         rd(`AAC_REG_ERR, err);
   endtask
endmodule // aac_host
`default_nettype wire

/* aac_regs.vh */
// register map, field codes and timing constants of the arm and calibrate command handler
`ifndef AAC_REGS_VH
`define AAC_REGS_VH
// register offsets (byte addresses, one word each)
`define AAC_REG_CMD 8'h00
`define AAC_REG_CMD_ARG 8'h04
`define AAC_REG_STATUS 8'h08
`define AAC_REG_ARM_SRC 8'h0c
`define AAC_REG_ARM_ZERO 8'h10
`define AAC_REG_ARM_SLOPE 8'h14
`define AAC_REG_CAL_OFFSET 8'h18
`define AAC_REG_CAL_GAIN 8'h1c
`define AAC_REG_ERR 8'h20
`define AAC_REG_ERR_COUNT 8'h24
`define AAC_REG_ID 8'h28
// command opcodes written to CMD[7:0]
`define AAC_OP_ARM_SOURCE 8'h01
`define AAC_OP_ARM_ZERO 8'h02
`define AAC_OP_ARM_SLOPE 8'h03
`define AAC_OP_START_ACQ 8'h04
`define AAC_OP_ABORT 8'h05
`define AAC_OP_CAL_VALUE 8'h10
`define AAC_OP_CAL_ZERO 8'h11
`define AAC_OP_COMMON 8'h20
// command word fields
`define AAC_CMD_OP_MSB 7
`define AAC_CMD_GRP_LSB 8
`define AAC_CMD_GRP_MSB 11
`define AAC_CMD_VAL_BIT 12
`define AAC_CMD_HAS_GRP 13
`define AAC_CMD_HAS_VAL 14
`define AAC_CMD_HAS_CH 15
`define AAC_CMD_CH_LSB 16
`define AAC_CMD_CH_MSB 19
`define AAC_CMD_QUAL_LSB 20
`define AAC_CMD_QUAL_MSB 31
// status bits
`define AAC_ST_CAL_BUSY 0
`define AAC_ST_OPC 1
`define AAC_ST_CAL_FAIL 2
// argument limits, millivolts
`define AAC_CAL_VAL_MIN_MV 32'd80
`define AAC_CAL_VAL_MAX_MV 32'd19900
`define AAC_RANGE_MAX_MV 32'd20000
// error codes
`define AAC_ERR_RANGE 16'h0001
`define AAC_ERR_CAL 16'h0002
// timing
`define AAC_CLK_HZ 40000000
`define AAC_BLINK_MS 250
`define AAC_BLINK_CYC (`AAC_CLK_HZ / 1000 * `AAC_BLINK_MS)
`define AAC_CAL_US 1000
`define AAC_CAL_CYC (`AAC_CLK_HZ / 1000000 * `AAC_CAL_US)
`define AAC_ID_VALUE 32'h00a5c001
`endif

/* aac_sync3.v */
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module aac_sync3 (
   input wire mclk,
   input wire reset_n,
   input wire din,
   output reg dout
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   // -------------------------------------------------
   // stages: first stage only feeds the second
   // -------------------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) dout <= s3_r; // change counts once two agree
      end
   end
endmodule // aac_sync3
`default_nettype wire
